// File: design/adc_ctl_pkg.sv
package adc_ctl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_TIMING = 8'h10;
  // control 1 field positions
  localparam int B_DONE = 0;
  localparam int B_SAMPLING = 1;
  localparam int B_AUTO_START = 2;
  localparam int B_SIM_SAMPLE = 3;
  localparam int B_TRIG_LO = 5;
  localparam int B_TWELVE = 10;
  localparam int B_ENABLE = 15;
  // control 2 field positions
  localparam int B_CHCNT_LO = 8;
  localparam logic [15:0] CTRL1_WMASK = 16'h84EE;
  localparam logic [15:0] CTRL2_WMASK = 16'hE77F;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  // interrupt status bits
  localparam int IRQ_CONV_DONE = 0;
  localparam int IRQ_SAMPLE_START = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // timing defaults in cycles
  localparam logic [7:0] SAMPLE_TIME_RESET = 8'h03;
  localparam logic [7:0] CONV_TIME_RESET = 8'h0E;
  localparam logic [7:0] CNT_ONE = 8'h01;
  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } ahb_req_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_e;
endpackage

// File: design/adc_sample_convert_control.sv
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// RULE1: twelve-bit mode forces simultaneous bit to zero
// RULE2: simultaneous, four-channel: channels 0..3 together
// RULE3: simultaneous, two-channel: channels 0,1 together
// RULE4: simultaneous off: channels sampled one by one; the code acquires all channels together, then converts them in turn
// RULE5: auto start re-sets sampling after conversion
// RULE6: manual start: software writes sampling bit one
// RULE7: sampling bit shows acquiring versus holding
// RULE8: manual trigger: software writes zero to convert
// RULE9: other triggers: hardware clears sampling bit
// RULE10: done set on completion, zero otherwise
// RULE11: software only writes zero to done
// RULE12: clearing done leaves operation undisturbed
// RULE13: done cleared when new conversion starts
// RULE14: auto-convert: counter times sampling then converts
// RULE15: single channel: simultaneous bit has no effect
// RULE16: writing one to done is ignored
module adc_sample_convert_control (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // external conversion trigger pin
  input wire logic ext_trigger,
  // converter side
  output logic [3:0] sh_acquire,
  output logic conv_start,
  output logic irq
);
  import adc_ctl_pkg::*;

  ////////////////////////////////////////////////////////////////////
  ahb_req_s req;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic [15:0] ctrl1_r;
  logic [15:0] ctrl2_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [7:0] sample_time_r;
  logic [7:0] conv_time_r;
  logic [7:0] cnt_r;
  logic [1:0] chan_r;
  logic [2:0] trig_sync_r;
  logic trig_seen_r;
  logic sampling_r;
  logic done_r;
  conv_state_e state_r;
  logic addr_ok;
  logic wr_c1;
  logic trig_edge;
  logic end_sample;
  logic sw_start;
  logic seq_last;
  logic conv_end;
  logic [2:0] trig_src;
  logic [1:0] chcnt;
  logic sim_eff;

  assign req = '{haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: hsize,
                 hsel: hsel, hready: hready};
  assign addr_ok = req.hsel && req.hready && req.htrans[1];
  assign trig_src = ctrl1_r[B_TRIG_LO +: 3];
  assign chcnt = ctrl2_r[B_CHCNT_LO +: 2];
  assign sim_eff = ctrl1_r[B_SIM_SAMPLE] && !ctrl1_r[B_TWELVE] && (chcnt != 2'h0); // [RULE1] [RULE15]
  assign wr_c1 = wr_pend_r && (addr_r == OFS_CTRL1);

  ////////////////////////////////////////////////////////////////////
  // bus slave: zero wait state, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && req.hwrite;
      rd_pend_r <= addr_ok && !req.hwrite;
      if (addr_ok) begin
        addr_r <= req.haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !req.hwrite) begin
      unique case (req.haddr[7:0])
        OFS_CTRL1: hrdata <= {16'h0000, ctrl1_r[15:4], sim_eff && ctrl1_r[B_SIM_SAMPLE],
                              ctrl1_r[B_AUTO_START], sampling_r, done_r}; // [RULE1] [RULE7]
        OFS_CTRL2: hrdata <= {16'h0000, ctrl2_r};
        OFS_IRQ_STAT: hrdata <= {30'h0000_0000, irq_stat_r};
        OFS_IRQ_MASK: hrdata <= {30'h0000_0000, irq_mask_r};
        OFS_TIMING: hrdata <= {16'h0000, conv_time_r, sample_time_r};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1_r <= CTRL_RESET;
      ctrl2_r <= CTRL_RESET;
      irq_mask_r <= IRQ_RESET;
      sample_time_r <= SAMPLE_TIME_RESET;
      conv_time_r <= CONV_TIME_RESET;
    end else if (wr_pend_r) begin
      if (addr_r == OFS_CTRL1) begin
        ctrl1_r <= (hwdata[15:0] & CTRL1_WMASK) | (ctrl1_r & ~CTRL1_WMASK);
      end
      if (addr_r == OFS_CTRL2) begin
        ctrl2_r <= (hwdata[15:0] & CTRL2_WMASK) | (ctrl2_r & ~CTRL2_WMASK);
      end
      if (addr_r == OFS_IRQ_MASK) begin
        irq_mask_r <= hwdata[1:0];
      end
      if (addr_r == OFS_TIMING) begin
        sample_time_r <= (hwdata[7:0] == 8'h00) ? CNT_ONE : hwdata[7:0];
        conv_time_r <= (hwdata[15:8] == 8'h00) ? CNT_ONE : hwdata[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // trigger pin synchroniser, edge when stages two and three agree high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_sync_r <= 3'h0;
      trig_seen_r <= 1'b0;
    end else begin
      trig_sync_r <= {trig_sync_r[1:0], ext_trigger};
      if (trig_sync_r[2] == trig_sync_r[1]) begin
        trig_seen_r <= trig_sync_r[2];
      end
    end
  end
  assign trig_edge = (trig_sync_r[2] == trig_sync_r[1]) && trig_sync_r[2] && !trig_seen_r;

  assign sw_start = wr_c1 && hwdata[B_SAMPLING] && !ctrl1_r[B_AUTO_START]; // [RULE6]
  always_comb begin
    end_sample = 1'b0;
    if (state_r == ST_SAMPLE) begin
      unique case (trig_src)
        TRIG_MANUAL: end_sample = wr_c1 && !hwdata[B_SAMPLING]; // [RULE8]
        TRIG_AUTO: end_sample = (cnt_r == CNT_ONE); // [RULE14]
        default: end_sample = trig_edge; // [RULE9]
      endcase
    end
  end
  assign conv_end = (state_r == ST_CONVERT) && (cnt_r == CNT_ONE);
  // sequential mode converts each channel in turn
  // count field 1x means four channels: last index is three, not the field value
  assign seq_last = sim_eff || (chcnt == 2'h0) || (!chcnt[1] && chan_r == 2'h1) ||
                    (chcnt[1] && chan_r == 2'h3); // [RULE4]

  ////////////////////////////////////////////////////////////////////
  // sample / convert sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      chan_r <= 2'h0;
      sampling_r <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (sw_start || ctrl1_r[B_AUTO_START]) begin
            state_r <= ST_SAMPLE;
            sampling_r <= 1'b1; // [RULE7]
            cnt_r <= sample_time_r;
            chan_r <= 2'h0;
          end
        end
        ST_SAMPLE: begin
          if (cnt_r != CNT_ONE) begin
            cnt_r <= cnt_r - CNT_ONE;
          end
          if (end_sample) begin
            state_r <= ST_CONVERT;
            sampling_r <= 1'b0;
            conv_start <= 1'b1;
            cnt_r <= conv_time_r;
          end
        end
        ST_CONVERT: begin
          cnt_r <= cnt_r - CNT_ONE;
          if (conv_end) begin
            if (!seq_last) begin
              chan_r <= chan_r + 2'h1;
              conv_start <= 1'b1;
              cnt_r <= conv_time_r;
            end else if (ctrl1_r[B_AUTO_START]) begin
              state_r <= ST_SAMPLE; // [RULE5]
              sampling_r <= 1'b1;
              cnt_r <= sample_time_r;
              chan_r <= 2'h0;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // done flag: hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r <= 1'b0;
    end else if (conv_end && seq_last) begin
      done_r <= 1'b1; // [RULE10]
    end else if (state_r == ST_SAMPLE && end_sample) begin
      done_r <= 1'b0; // [RULE13]
    end else if (wr_c1 && !hwdata[B_DONE]) begin
      done_r <= 1'b0; // [RULE12] [RULE16]
    end
  end

  // acquire lines per channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_acquire <= 4'h0;
    end else if (state_r == ST_SAMPLE && !end_sample) begin
      if (sim_eff && chcnt[1]) begin
        sh_acquire <= 4'hF; // [RULE2]
      end else if (sim_eff) begin
        sh_acquire <= 4'h3; // [RULE3]
      end else if (chcnt == 2'h0) begin
        sh_acquire <= 4'h1;
      end else begin
        sh_acquire <= chcnt[1] ? 4'hF : 4'h3; // [RULE4]
      end
    end else begin
      sh_acquire <= 4'h0;
    end
  end

  // interrupt status, cleared by read, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irq_stat_r[IRQ_CONV_DONE] <= (conv_end && seq_last) ||
        (irq_stat_r[IRQ_CONV_DONE] && !(rd_pend_r && addr_r == OFS_IRQ_STAT));
      // set on every entry to sampling, auto restart included
      irq_stat_r[IRQ_SAMPLE_START] <=
        (state_r == ST_IDLE && (sw_start || ctrl1_r[B_AUTO_START])) ||
        (conv_end && seq_last && ctrl1_r[B_AUTO_START]) ||
        (irq_stat_r[IRQ_SAMPLE_START] && !(rd_pend_r && addr_r == OFS_IRQ_STAT));
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////
  a_done_on_end: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_end && seq_last |=> done_r) else $error("done not set"); // [RULE10]
  a_done_clr_start: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == ST_SAMPLE && end_sample && !(conv_end && seq_last) |=> !done_r)
    else $error("done not cleared"); // [RULE13]
  a_done_no_set: assert property (@(posedge hclk) disable iff (!hresetn)
    !done_r && !(conv_end && seq_last) |=> !done_r) else $error("done set by write"); // [RULE16]
  a_manual_start: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == ST_IDLE && !ctrl1_r[B_AUTO_START] && !sw_start |=> state_r == ST_IDLE)
    else $error("unrequested sampling"); // [RULE6]
  a_auto_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_end && seq_last && ctrl1_r[B_AUTO_START] |=> sampling_r)
    else $error("no auto restart"); // [RULE5]
  a_samp_state: assert property (@(posedge hclk) disable iff (!hresetn)
    sampling_r == (state_r == ST_SAMPLE)) else $error("sampling bit mismatch"); // [RULE7]
  a_manual_end: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == ST_SAMPLE && trig_src == TRIG_MANUAL && !wr_c1 |=> state_r == ST_SAMPLE)
    else $error("manual sample ended"); // [RULE8]
  a_auto_time: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == ST_SAMPLE && trig_src == TRIG_AUTO && cnt_r == CNT_ONE
    |=> state_r == ST_CONVERT ##0 conv_start) else $error("auto convert missing"); // [RULE14]
  a_sim_four: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == ST_SAMPLE && !end_sample && sim_eff && chcnt[1] |=> sh_acquire == 4'hF)
    else $error("four channel sample"); // [RULE2]
  a_twelve_sim: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl1_r[B_TWELVE] |-> !sim_eff) else $error("simultaneous in twelve bit"); // [RULE1]
endmodule // adc_sample_convert_control

// File: bench/test_adc_sample_convert_control.sv
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module test_adc_sample_convert_control;
  import adc_ctl_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic ext_trigger = 1'b0;
  logic [3:0] sh_acquire;
  logic conv_start;
  logic irq;
  int fail_count = 0;
  int check_count = 0;
  int pulses = 0;
  logic [31:0] rv;
  ////////////////////////////////////////////////////////////////////////
  adc_sample_convert_control u_adc_sample_convert_control (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_trigger(ext_trigger),
    .sh_acquire(sh_acquire), .conv_start(conv_start), .irq(irq)
  );
  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  // counts per-channel conversion pulses
  always @(posedge hclk) begin
    if (conv_start === 1'b1) pulses <= pulses + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
  endtask
  // one single transfer; an idle edge first keeps drivers apart
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // polls control 1 until the masked bits match
  task automatic wait_bit(input logic [31:0] m, input logic [31:0] want);
    int n;
    n = 0;
    do begin
      rd(OFS_CTRL1);
      n++;
    end while ((rv & m) !== want && n < 300);
    if ((rv & m) !== want) begin
      fail_count++;
      give_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_CTRL1);
    `CHK(rv, 32'h0000);
    `CHK(hreadyout, 1'b1);
    `CHK(hresp, 1'b0);
    rd(OFS_CTRL2);
    `CHK(rv, 32'h0000);
    wr(8'h20, 32'h1234);
    rd(8'h20);
    `CHK(rv, 32'h0000);
    // longer sampling so polling sees each phase
    wr(OFS_TIMING, 32'h0E10);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_CTRL2, 32'h0200);
    wr(OFS_CTRL1, 32'h8008);
    rd(OFS_CTRL1);
    `CHK(rv, 32'h8008);
    wr(OFS_CTRL1, 32'h8408);
    rd(OFS_CTRL1);
    `CHK(rv, 32'h8400);
    wr(OFS_CTRL1, 32'h800A);
    rd(OFS_CTRL1);
    `CHK(rv, 32'h800A);
    `CHK(sh_acquire, 4'hF);
    wr(OFS_CTRL1, 32'h8008);
    rd(OFS_CTRL1);
    `CHK(rv, 32'h8008);
    `CHK(sh_acquire, 4'h0);
    wait_bit(32'h3, 32'h1);
    `CHK(rv, 32'h8009);
    `CHK(irq, 1'b1);
    rd(OFS_IRQ_STAT);
    `CHK(rv, 32'h3);
    repeat (3) @(posedge hclk);
    `CHK(irq, 1'b0);
    wr(OFS_CTRL1, 32'h8008);
    rd(OFS_CTRL1);
    `CHK(rv, 32'h8008);
    wr(OFS_CTRL1, 32'h8009);
    rd(OFS_CTRL1);
    `CHK(rv, 32'h8008);
    // two channels together, interrupt masked
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_CTRL2, 32'h0100);
    wr(OFS_CTRL1, 32'h800A);
    rd(OFS_CTRL1);
    `CHK(sh_acquire, 4'h3);
    wr(OFS_CTRL1, 32'h8008);
    wait_bit(32'h3, 32'h1);
    `CHK(irq, 1'b0);
    // single channel
    wr(OFS_CTRL2, 32'h0000);
    rd(OFS_CTRL1);
    `CHK(rv, 32'h8001);
    wr(OFS_CTRL1, 32'h800A);
    rd(OFS_CTRL1);
    `CHK(sh_acquire, 4'h1);
    wr(OFS_CTRL1, 32'h8008);
    wait_bit(32'h3, 32'h1);
    // four channels in sequence, done cleared mid conversion
    wr(OFS_CTRL2, 32'h0200);
    wr(OFS_CTRL1, 32'h8002);
    pulses = 0;
    wr(OFS_CTRL1, 32'h8000);
    wr(OFS_CTRL1, 32'h8000);
    wait_bit(32'h3, 32'h1);
    `CHK(pulses, 4);
    // external trigger ends sampling
    wr(OFS_CTRL2, 32'h0000);
    wr(OFS_CTRL1, 32'h8022);
    rd(OFS_CTRL1);
    `CHK(rv, 32'h8022);
    @(posedge hclk);
    ext_trigger <= 1'b1;
    repeat (5) @(posedge hclk);
    ext_trigger <= 1'b0;
    wait_bit(32'h3, 32'h1);
    `CHK(rv, 32'h8021);
    // auto-convert with auto start
    // counter ends sampling: converting, done still clear
    wr(OFS_CTRL1, 32'h80E4);
    wait_bit(32'h3, 32'h0);
    `CHK(rv & 32'h3, 32'h0);
    wait_bit(32'h3, 32'h3);
    `CHK(rv & 32'h3, 32'h3);
    wait_bit(32'h3, 32'h0);
    `CHK(rv & 32'h3, 32'h0);
    wr(OFS_CTRL1, 32'h8000);
    give_verdict();
  end
endmodule // test_adc_sample_convert_control
